// ===== hdl/igp_pkg.sv
package igp_pkg;
    // Timing figures in ns, PWM frequency in Hz
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEAD_TIME_NS = 3300;
    localparam int PWM_MAX_FREQ_HZ = 15000;
    localparam int MIN_ON_NS = 1500;
    localparam int MIN_OFF_LOW_NS = 2600;
    localparam int MIN_OFF_HIGH_NS = 2800;
    // Derived cycle counts, least times round up
    localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_OFF_LOW_CYC = (MIN_OFF_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_OFF_HIGH_CYC = (MIN_OFF_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least PWM period in cycles (100 MHz / 15 kHz, rounded up)
    localparam int MIN_PERIOD_CYC = (1000000000 / CLK_PERIOD_NS + PWM_MAX_FREQ_HZ - 1)
        / PWM_MAX_FREQ_HZ;
    localparam int CNT_W = 16;
    localparam int SYNC_STAGES = 2;
endpackage : igp_pkg

// ===== hdl/igp_leg.sv
`timescale 1ns/1ns
module igp_leg #(
    parameter int CNT_W = igp_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic dutyHigh,
    input wire logic inhibit,
    input wire logic heavyLoad,
    output logic gateHigh,
    output logic gateLow
);
    typedef enum logic [3:0] {
        IGP_OFF = 4'b0001,
        IGP_HIGH = 4'b0010,
        IGP_DEAD = 4'b0100,
        IGP_LOW = 4'b1000
    } igp_leg_state_t;

    igp_leg_state_t state_reg;
    logic [CNT_W-1:0] timer_reg;
    logic [CNT_W-1:0] period_reg;
    logic target_reg;
    logic timerDone;
    logic [CNT_W-1:0] offMin;

    assign timerDone = (timer_reg == '0);
    assign offMin = heavyLoad ? CNT_W'(igp_pkg::MIN_OFF_HIGH_CYC)
                              : CNT_W'(igp_pkg::MIN_OFF_LOW_CYC);

    // Counts up, saturating, since the last cycle in IGP_DEAD with the timer done and the high side as target
    always_ff @(posedge clk) begin
        if (!rstn) begin
            period_reg <= '0;
        end else if (state_reg == IGP_DEAD && timerDone && target_reg) begin
            period_reg <= '0;
        end else if (period_reg != {CNT_W{1'b1}}) begin
            period_reg <= period_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= IGP_OFF;
            timer_reg <= '0;
            target_reg <= 1'b0;
        end else if (inhibit) begin
            state_reg <= IGP_OFF;
            timer_reg <= CNT_W'(igp_pkg::DEAD_CYC);
            target_reg <= 1'b0;
        end else begin
            if (!timerDone) begin
                timer_reg <= timer_reg - 1'b1;
            end
            unique case (state_reg)
                IGP_OFF: begin
                    if (timerDone) begin
                        state_reg <= IGP_DEAD;
                        target_reg <= dutyHigh;
                        timer_reg <= '0;
                    end
                end
                IGP_DEAD: begin
                    if (timerDone && (!target_reg || period_reg >=
                            CNT_W'(igp_pkg::MIN_PERIOD_CYC))) begin
                        state_reg <= target_reg ? IGP_HIGH : IGP_LOW;
                        timer_reg <= CNT_W'(igp_pkg::MIN_ON_CYC);
                    end
                end
                IGP_HIGH, IGP_LOW: begin
                    if (timerDone && (dutyHigh != target_reg)) begin
                        state_reg <= IGP_DEAD;
                        target_reg <= dutyHigh;
                        timer_reg <= (offMin > CNT_W'(igp_pkg::DEAD_CYC)) ? offMin
                                   : CNT_W'(igp_pkg::DEAD_CYC);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            gateHigh <= 1'b0;
            gateLow <= 1'b0;
        end else begin
            gateHigh <= !inhibit && (state_reg == IGP_HIGH);
            gateLow <= !inhibit && (state_reg == IGP_LOW);
        end
    end
endmodule : igp_leg

// ===== hdl/igp_controller.sv
// Overview of operation
// - Wait at least 3.3 us between one switch off and its partner on.
// - Never switch a high-side gate on faster than 15 kHz; low-side turn-ons are not limited.
// - Every on pulse lasts at least 1.5 us, except one cut short by disable or a fault.
// - Off intervals last at least 2.6 us, or 2.8 us above 5 A.
`timescale 1ns/1ns
module igp_controller #(
    parameter int CNT_W = igp_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic phaseADuty,
    input wire logic phaseBDuty,
    input wire logic phaseCDuty,
    input wire logic heavyLoad,
    input wire logic faultClear,
    input wire logic fault_out_n,
    output logic phase_a_high_gate_in,
    output logic phase_a_low_gate_in,
    output logic phase_b_high_gate_in,
    output logic phase_b_low_gate_in,
    output logic phase_c_high_gate_in,
    output logic phase_c_low_gate_in,
    output logic faultActive,
    output logic faultLatched
);
    logic [igp_pkg::SYNC_STAGES-1:0] faultSync_reg;
    logic faultSeen;
    logic faultLatch_reg;
    logic faultActive_reg;
    logic inhibit;
    logic [2:0] duty;
    logic [2:0] gateHigh;
    logic [2:0] gateLow;
    logic [2:0] heavy_reg;
    logic [2:0] dutySync_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            faultSync_reg <= '1;
        end else begin
            faultSync_reg <= {faultSync_reg[0], fault_out_n};
        end
    end
    assign faultSeen = !faultSync_reg[igp_pkg::SYNC_STAGES-1];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            faultLatch_reg <= 1'b0;
            faultActive_reg <= 1'b0;
        end else begin
            faultActive_reg <= faultSeen;
            if (faultSeen) begin
                faultLatch_reg <= 1'b1;
            end else if (faultClear) begin
                faultLatch_reg <= 1'b0;
            end
        end
    end

    assign inhibit = !enable || faultSeen || faultLatch_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            heavy_reg <= '0;
            dutySync_reg <= '0;
        end else begin
            heavy_reg <= {3{heavyLoad}};
            dutySync_reg <= {phaseCDuty, phaseBDuty, phaseADuty};
        end
    end
    assign duty = dutySync_reg;

    for (genvar i = 0; i < 3; i++) begin : g_leg
        igp_leg #(
            .CNT_W(CNT_W)
        ) u_leg (
            .clk(clk),
            .rstn(rstn),
            .dutyHigh(duty[i]),
            .inhibit(inhibit),
            .heavyLoad(heavy_reg[i]),
            .gateHigh(gateHigh[i]),
            .gateLow(gateLow[i])
        );
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phase_a_high_gate_in <= 1'b0;
            phase_a_low_gate_in <= 1'b0;
            phase_b_high_gate_in <= 1'b0;
            phase_b_low_gate_in <= 1'b0;
            phase_c_high_gate_in <= 1'b0;
            phase_c_low_gate_in <= 1'b0;
            faultActive <= 1'b0;
            faultLatched <= 1'b0;
        end else begin
            phase_a_high_gate_in <= gateHigh[0] && !inhibit;
            phase_a_low_gate_in <= gateLow[0] && !inhibit;
            phase_b_high_gate_in <= gateHigh[1] && !inhibit;
            phase_b_low_gate_in <= gateLow[1] && !inhibit;
            phase_c_high_gate_in <= gateHigh[2] && !inhibit;
            phase_c_low_gate_in <= gateLow[2] && !inhibit;
            faultActive <= faultActive_reg;
            faultLatched <= faultLatch_reg;
        end
    end
endmodule : igp_controller

// ===== dv/igp_module_model.sv
`timescale 1ns/1ns
module igp_module_model #(
    parameter int FO_CYC = 200
) (
    input wire logic clk,
    input wire logic trip,
    input wire logic uvLow,
    output wire logic faultOutN
);
    int foCnt = 0;
    always @(posedge clk) begin
        foCnt <= (trip || uvLow) ? FO_CYC : ((foCnt > 0) ? foCnt - 1 : 0);
    end
    assign faultOutN = (foCnt > 0) ? 1'b0 : 1'bz;
    pullup (faultOutN);
endmodule : igp_module_model

// ===== dv/igp_controller_asserts.sv
`timescale 1ns/1ns
module igp_controller_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic heavyLoad,
    input wire logic faultClear,
    input wire logic fault_out_n,
    input wire logic phase_a_high_gate_in,
    input wire logic phase_a_low_gate_in,
    input wire logic faultActive,
    input wire logic faultLatched
);
    logic [15:0] sinceRise;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sinceRise <= 16'hFFFF;
        end else if ($rose(phase_a_high_gate_in)) begin
            sinceRise <= 16'h0001;
        end else if (sinceRise != 16'hFFFF) begin
            sinceRise <= sinceRise + 16'h0001;
        end
    end
    property p_period;
        $rose(phase_a_high_gate_in) |-> sinceRise >= 16'(igp_pkg::MIN_PERIOD_CYC);
    endproperty
    a_period: assert property (p_period) else $error("switching too fast");
    property p_dead;
        $rose(phase_a_high_gate_in) |-> !$past(phase_a_low_gate_in, igp_pkg::DEAD_CYC);
    endproperty
    a_dead: assert property (p_dead) else $error("dead time short");
    property p_on;
        $fell(phase_a_high_gate_in) && enable && !faultActive && !faultLatched
            |-> $past(phase_a_high_gate_in, igp_pkg::MIN_ON_CYC);
    endproperty
    a_on: assert property (p_on) else $error("on pulse short");
    property p_off;
        $rose(phase_a_high_gate_in) && heavyLoad
            |-> !$past(phase_a_high_gate_in, igp_pkg::MIN_OFF_HIGH_CYC);
    endproperty
    a_off: assert property (p_off) else $error("off pulse short");
    property p_inhibit;
        faultActive && $past(faultActive) |-> !(phase_a_high_gate_in || phase_a_low_gate_in);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("gate on in fault");
    property p_sync;
        !fault_out_n [*5] |-> faultActive;
    endproperty
    a_sync: assert property (p_sync) else $error("fault not seen");
    property p_latch;
        faultLatched && !faultClear && !$past(faultClear) |=> faultLatched;
    endproperty
    a_latch: assert property (p_latch) else $error("latch lost");
endmodule : igp_controller_asserts
bind igp_controller igp_controller_asserts i_igp_controller_asserts (.clk, .rstn, .enable,
    .heavyLoad, .faultClear, .fault_out_n, .phase_a_high_gate_in, .phase_a_low_gate_in,
    .faultActive, .faultLatched);

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, rstn = 1'b0, enable = 1'b0, heavyLoad = 1'b0, faultClear = 1'b0;
    logic trip = 1'b0, uvLow = 1'b0, faultActive, faultLatched;
    logic [2:0] duty = 3'h0;
    logic [5:0] cur = 6'h15, prevGates = 6'h00;
    logic [5:0] expQ[$];
    wire [5:0] gates;
    wire logic faultOutN;
    int fails = 0, checks_done = 0, cycles = 0, seed = 32'h118f, p;
    igp_controller i_igp_controller (.clk, .rstn, .enable, .heavyLoad, .faultClear,
        .phaseADuty(duty[2]), .phaseBDuty(duty[1]), .phaseCDuty(duty[0]),
        .fault_out_n(faultOutN), .faultActive, .faultLatched,
        .phase_a_high_gate_in(gates[5]), .phase_a_low_gate_in(gates[4]),
        .phase_b_high_gate_in(gates[3]), .phase_b_low_gate_in(gates[2]),
        .phase_c_high_gate_in(gates[1]), .phase_c_low_gate_in(gates[0]));
    igp_module_model i_igp_module_model (.clk, .trip, .uvLow, .faultOutN);
    always #5 clk = ~clk;
    task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            fails++;
            summarize();
        end
    end
    // Each change of the gate vector takes the oldest note
    always @(negedge clk) begin
        prevGates <= gates;
        if (rstn && gates !== prevGates) begin
            if (expQ.size() == 0)
                check("extra gates", gates, prevGates);
            else
                check("gates", gates, expQ.pop_front());
        end
    end
    initial begin
        tick(6);
        rstn <= 1'b1;
        enable <= 1'b1;
        heavyLoad <= 1'($random(seed));
        expQ.push_back(6'h15);
        tick(7400);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            p = $unsigned($random(seed)) % 3;
            expQ.push_back(cur & ~(6'h30 >> (2 * p)));
            cur[5 - 2 * p -: 2] = duty[2 - p] ? 2'b01 : 2'b10;
            expQ.push_back(cur);
            duty[2 - p] <= ~duty[2 - p];
            tick(7400);
            $display("test toggle %0d done", i);
        end
        for (int k = 0; k < 3; k++) begin
            trip <= (k == 0);
            uvLow <= (k == 1);
            enable <= (k != 2);
            expQ.push_back(6'h00);
            tick(1);
            trip <= 1'b0;
            tick(450);
            check("active", {5'h00, faultActive}, {5'h00, k == 1});
            if (k == 2)
                expQ.push_back(cur);
            enable <= 1'b1;
            uvLow <= 1'b0;
            tick(220);
            check("latched", {5'h00, faultLatched}, {5'h00, k != 2});
            faultClear <= 1'b1;
            if (k != 2)
                expQ.push_back(cur);
            tick(1);
            faultClear <= 1'b0;
            tick(7400);
            $display("test refusal %0d done", k);
        end
        check("queue", 6'(expQ.size()), 6'h00);
        summarize();
    end
endmodule : tb
